// ==== pkg/bwc_pkg.sv ====
// bwc_pkg: offsets, reset values and field positions of the bridge window and control registers
package bwc_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_PREF_BASE_UPPER = 8'h28;
    localparam logic [7:0] OFF_PREF_LIMIT_UPPER = 8'h2c;
    localparam logic [7:0] OFF_IO_UPPER = 8'h30;
    localparam logic [7:0] OFF_CAP_PTR = 8'h34;
    localparam logic [7:0] OFF_INT_CTRL = 8'h3c;
    localparam logic [7:0] OFF_PM_CAP = 8'h40;
    // ----------------------------------------------------------------
    // reset and constant values
    // ----------------------------------------------------------------
    localparam logic [31:0] RST_PREF_UPPER = 32'h0000_0000;
    localparam logic [15:0] RST_IO_UPPER = 16'h0000;
    localparam logic [7:0] CAP_PTR_VALUE = 8'h40;
    localparam logic [7:0] PM_CAP_ID = 8'h01;
    localparam logic [7:0] RST_INT_LINE = 8'h00;
    localparam logic [7:0] RST_INT_PIN = 8'h00;
    // ----------------------------------------------------------------
    // bridge control bit positions within the 0x3c word
    // ----------------------------------------------------------------
    localparam int BIT_PARITY_RESP = 16;
    localparam int BIT_SERR_FWD = 17;
    localparam int BIT_ISA_EN = 18;
    localparam int BIT_VGA_EN = 19;
    localparam int BIT_VGA16 = 20;
    localparam int BIT_SEC_RESET = 22;
    // ----------------------------------------------------------------
    // legacy decode ranges and window limit fill values
    // ----------------------------------------------------------------
    localparam logic [63:0] VGA_MEM_LO = 64'h0000_0000_000a_0000;
    localparam logic [63:0] VGA_MEM_HI = 64'h0000_0000_000b_ffff;
    localparam logic [9:0] VGA_IO_A_LO = 10'h3b0;
    localparam logic [9:0] VGA_IO_A_HI = 10'h3bb;
    localparam logic [9:0] VGA_IO_B_LO = 10'h3c0;
    localparam logic [9:0] VGA_IO_B_HI = 10'h3df;
    localparam logic [19:0] PREF_LIMIT_FILL = 20'hfffff;
    localparam logic [11:0] IO_LIMIT_FILL = 12'hfff;
endpackage

// ==== rtl/bwc_regs.sv ====
// bwc_regs: bridge window upper halves, capability pointer, interrupt and bridge control registers
`timescale 1ns/1ps
// Functional notes
// - prefetch limit upper 32 bits, RW, reset zero
// - I/O base upper 16 bits, low half
// - I/O limit upper 16 bits, high half
// - capability pointer reads 40h, read only
// - interrupt pin field resets to zero, read only
// - downstream pin default loadable, else zero
// - bit 16 enables secondary poisoned packet reporting
// - bit 17 gates secondary error message forwarding
// - bit 18: ISA, only top 768 bytes forwarded
// - bit 19 enables legacy display range forwarding
// - display memory A0000h through BFFFFh inclusive
// - display I/O 3B0-3BBh, 3C0-3DFh, first 64KB
// - bit 20 selects 16-bit versus 10-bit compare
// - bit 22 downstream: hot reset, port reset
// - bit 22 upstream: reset all downstream ports
// - control bits 21, 23-27 read zero
// - prefetch base upper 32 bits, RW, zero
// - capability block starts with power management id
module bwc_regs
    import bwc_pkg::*;
#(
    parameter int N_DOWN = 2
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // avalon-mm slave
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // port role and lower window fields held elsewhere
    input wire logic i_port_is_upstream,
    input wire logic [11:0] i_pref_base_low,
    input wire logic [11:0] i_pref_limit_low,
    input wire logic [3:0] i_io_base_low,
    input wire logic [3:0] i_io_limit_low,
    // interrupt pin default loader (management port or config memory)
    input wire logic i_int_pin_load,
    input wire logic [7:0] i_int_pin_value,
    // transaction to classify
    input wire logic i_txn_valid,
    input wire logic i_txn_is_io,
    input wire logic i_txn_poisoned,
    input wire logic [63:0] i_txn_addr,
    input wire logic i_err_msg_valid,
    input wire logic i_upstream_hot_reset,
    // classification results
    output logic o_pref_hit,
    output logic o_io_hit,
    output logic o_vga_hit,
    output logic o_poison_report,
    output logic o_err_forward,
    // resets toward attached devices
    output logic o_port_reset,
    output logic [N_DOWN-1:0] o_downstream_reset
);
    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [31:0] pref_base_upper;
    logic [31:0] pref_limit_upper;
    logic [15:0] io_base_upper;
    logic [15:0] io_limit_upper;
    logic [7:0] interrupt_routing_line;
    logic [7:0] interrupt_pin_select;
    logic parity_resp;
    logic secondary_error_forward_enable;
    logic isa_enable;
    logic vga_enable;
    logic vga_decode16;
    logic sec_bus_reset;

    logic wr_fire;
    logic rd_take;
    logic [31:0] bridge_control;
    logic [31:0] io_merged;

    function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = data[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic in_window(input logic [63:0] addr, input logic [63:0] lo,
                                       input logic [63:0] hi);
        return (addr >= lo) && (addr <= hi);
    endfunction

    // ----------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------
    // every access answers exactly one cycle after it is presented
    assign wr_fire = i_avs_write && !o_avs_waitrequest;
    assign rd_take = i_avs_read && o_avs_waitrequest;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_avs_waitrequest <= 1'b1;
        end else begin
            o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
        end
    end

    // ----------------------------------------------------------------
    // writable fields
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pref_base_upper <= RST_PREF_UPPER;
            pref_limit_upper <= RST_PREF_UPPER;
        end else if (wr_fire && i_avs_address[7:2] == OFF_PREF_BASE_UPPER[7:2]) begin
            pref_base_upper <= merge_be(pref_base_upper, i_avs_writedata, i_avs_byteenable);
        end else if (wr_fire && i_avs_address[7:2] == OFF_PREF_LIMIT_UPPER[7:2]) begin
            pref_limit_upper <= merge_be(pref_limit_upper, i_avs_writedata, i_avs_byteenable);
        end
    end

    assign io_merged = merge_be({io_limit_upper, io_base_upper}, i_avs_writedata, i_avs_byteenable);

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            io_base_upper <= RST_IO_UPPER;
            io_limit_upper <= RST_IO_UPPER;
        end else if (wr_fire && i_avs_address[7:2] == OFF_IO_UPPER[7:2]) begin
            io_base_upper <= io_merged[15:0];
            io_limit_upper <= io_merged[31:16];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            interrupt_routing_line <= RST_INT_LINE;
        end else if (wr_fire && i_avs_address[7:2] == OFF_INT_CTRL[7:2] && i_avs_byteenable[0]) begin
            interrupt_routing_line <= i_avs_writedata[7:0];
        end
    end

    // pin field is read-only to software; only the loader may replace it, and only downstream
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            interrupt_pin_select <= RST_INT_PIN;
        end else if (i_int_pin_load && !i_port_is_upstream) begin
            interrupt_pin_select <= i_int_pin_value;
        end
    end

    // only the six implemented control bits are stored; the rest have no flops
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            parity_resp <= 1'b0;
            secondary_error_forward_enable <= 1'b0;
            isa_enable <= 1'b0;
            vga_enable <= 1'b0;
            vga_decode16 <= 1'b0;
            sec_bus_reset <= 1'b0;
        end else if (wr_fire && i_avs_address[7:2] == OFF_INT_CTRL[7:2]) begin
            if (i_avs_byteenable[2]) begin
                parity_resp <= i_avs_writedata[BIT_PARITY_RESP];
                secondary_error_forward_enable <= i_avs_writedata[BIT_SERR_FWD];
                isa_enable <= i_avs_writedata[BIT_ISA_EN];
                vga_enable <= i_avs_writedata[BIT_VGA_EN];
                vga_decode16 <= i_avs_writedata[BIT_VGA16];
                sec_bus_reset <= i_avs_writedata[BIT_SEC_RESET];
            end
        end
    end

    always_comb begin
        bridge_control = 32'h0000_0000;
        bridge_control[BIT_PARITY_RESP] = parity_resp;
        bridge_control[BIT_SERR_FWD] = secondary_error_forward_enable;
        bridge_control[BIT_ISA_EN] = isa_enable;
        bridge_control[BIT_VGA_EN] = vga_enable;
        bridge_control[BIT_VGA16] = vga_decode16;
        bridge_control[BIT_SEC_RESET] = sec_bus_reset;
        bridge_control[15:8] = interrupt_pin_select;
        bridge_control[7:0] = interrupt_routing_line;
    end

    // ----------------------------------------------------------------
    // read data, captured when the request is first seen
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (rd_take) begin
            unique case (i_avs_address[7:2])
                OFF_PREF_BASE_UPPER[7:2]: o_avs_readdata <= pref_base_upper;
                OFF_PREF_LIMIT_UPPER[7:2]: o_avs_readdata <= pref_limit_upper;
                OFF_IO_UPPER[7:2]: o_avs_readdata <= {io_limit_upper, io_base_upper};
                OFF_CAP_PTR[7:2]: o_avs_readdata <= {24'h000000, CAP_PTR_VALUE};
                OFF_INT_CTRL[7:2]: o_avs_readdata <= bridge_control;
                OFF_PM_CAP[7:2]: o_avs_readdata <= {24'h000000, PM_CAP_ID};
                default: o_avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // forwarding decode
    // ----------------------------------------------------------------
    logic [63:0] pref_lo;
    logic [63:0] pref_hi;
    logic [63:0] io_lo;
    logic [63:0] io_hi;
    logic io_first64k;
    logic isa_masked;
    logic vga_io_match;
    logic vga_mem_match;

    assign pref_lo = {pref_base_upper, i_pref_base_low, 20'h00000};
    assign pref_hi = {pref_limit_upper, i_pref_limit_low, PREF_LIMIT_FILL};
    assign io_lo = {32'h0000_0000, io_base_upper, i_io_base_low, 12'h000};
    assign io_hi = {32'h0000_0000, io_limit_upper, i_io_limit_low, IO_LIMIT_FILL};
    assign io_first64k = (i_txn_addr[63:16] == 48'h0);
    // the bottom 256 bytes of each 1KB block in the first 64KB stay out of the window under ISA mode
    assign isa_masked = isa_enable && io_first64k && (i_txn_addr[9:8] == 2'b00);
    assign vga_mem_match = (i_txn_addr >= VGA_MEM_LO) && (i_txn_addr <= VGA_MEM_HI);
    // 10-bit mode aliases the ports across the first 64KB; 16-bit mode also wants bits 15:10 clear
    assign vga_io_match = io_first64k && (!vga_decode16 || i_txn_addr[15:10] == 6'h00)
        && (((i_txn_addr[9:0] >= VGA_IO_A_LO) && (i_txn_addr[9:0] <= VGA_IO_A_HI))
        || ((i_txn_addr[9:0] >= VGA_IO_B_LO) && (i_txn_addr[9:0] <= VGA_IO_B_HI)));

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_pref_hit <= 1'b0;
            o_io_hit <= 1'b0;
            o_vga_hit <= 1'b0;
        end else begin
            o_pref_hit <= i_txn_valid && !i_txn_is_io && in_window(i_txn_addr, pref_lo, pref_hi);
            o_io_hit <= i_txn_valid && i_txn_is_io && in_window(i_txn_addr, io_lo, io_hi) && !isa_masked;
            o_vga_hit <= i_txn_valid && vga_enable && (i_txn_is_io ? vga_io_match : vga_mem_match);
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_poison_report <= 1'b0;
            o_err_forward <= 1'b0;
        end else begin
            o_poison_report <= i_txn_valid && i_txn_poisoned && parity_resp;
            o_err_forward <= i_err_msg_valid && secondary_error_forward_enable;
        end
    end

    // ----------------------------------------------------------------
    // hot reset outputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_port_reset <= 1'b0;
            o_downstream_reset <= '0;
        end else begin
            o_port_reset <= (sec_bus_reset && !i_port_is_upstream) || i_upstream_hot_reset;
            o_downstream_reset <= {N_DOWN{sec_bus_reset && i_port_is_upstream}};
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    // bus handshake and register fields
    wait_one_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest)
        else $error("access not answered after one cycle");

    pref_base_a: assert property (wr_fire && i_avs_address[7:2] == OFF_PREF_BASE_UPPER[7:2]
        && i_avs_byteenable == 4'hf |=> pref_base_upper == $past(i_avs_writedata))
        else $error("prefetch base upper write lost");

    pref_limit_a: assert property (wr_fire && i_avs_address[7:2] == OFF_PREF_LIMIT_UPPER[7:2]
        && i_avs_byteenable == 4'hf |=> pref_limit_upper == $past(i_avs_writedata))
        else $error("prefetch limit upper write lost");

    io_halves_a: assert property (wr_fire && i_avs_address[7:2] == OFF_IO_UPPER[7:2]
        && i_avs_byteenable == 4'hf |=> {io_limit_upper, io_base_upper} == $past(i_avs_writedata))
        else $error("io upper halves write lost");

    io_limit_a: assert property (wr_fire && i_avs_address[7:2] == OFF_IO_UPPER[7:2]
        && i_avs_byteenable[3:2] == 2'b11 |=> io_limit_upper == $past(i_avs_writedata[31:16]))
        else $error("io limit upper write lost");

    cap_ptr_a: assert property (!o_avs_waitrequest && i_avs_read
        && i_avs_address[7:2] == OFF_CAP_PTR[7:2] |-> o_avs_readdata == 32'h0000_0040)
        else $error("capability pointer wrong");

    pm_id_a: assert property (!o_avs_waitrequest && i_avs_read
        && i_avs_address[7:2] == OFF_PM_CAP[7:2] |-> o_avs_readdata == 32'h0000_0001)
        else $error("power management id wrong");

    ctl_zero_a: assert property (!o_avs_waitrequest && i_avs_read
        && i_avs_address[7:2] == OFF_INT_CTRL[7:2] |-> o_avs_readdata[31:23] == 9'h000 && !o_avs_readdata[21])
        else $error("hardwired control bits not zero");

    rsvd_zero_a: assert property (!o_avs_waitrequest && i_avs_read
        && i_avs_address[7:2] == OFF_INT_CTRL[7:2] |-> o_avs_readdata[31:28] == 4'h0)
        else $error("reserved control bits not zero");

    // interrupt pin field
    pin_upstream_a: assert property (i_port_is_upstream && i_int_pin_load
        |=> $stable(interrupt_pin_select))
        else $error("pin field changed on upstream port");

    pin_load_a: assert property (i_int_pin_load && !i_port_is_upstream
        |=> interrupt_pin_select == $past(i_int_pin_value))
        else $error("pin field default not loaded");

    // forwarding decode
    poison_gate_a: assert property (i_txn_valid && i_txn_poisoned
        |=> o_poison_report == $past(parity_resp))
        else $error("poison report not gated by control");

    err_gate_a: assert property (i_err_msg_valid && !secondary_error_forward_enable
        |=> !o_err_forward)
        else $error("error message forwarded while blocked");

    err_pass_a: assert property (i_err_msg_valid && secondary_error_forward_enable
        |=> o_err_forward)
        else $error("error message not forwarded");

    pref_hit_a: assert property (i_txn_valid && !i_txn_is_io && i_txn_addr == pref_lo
        && pref_lo <= pref_hi |=> o_pref_hit)
        else $error("prefetch window low edge missed");

    isa_mask_a: assert property (i_txn_valid && i_txn_is_io && isa_enable && io_first64k
        && i_txn_addr[9:8] == 2'b00 |=> !o_io_hit)
        else $error("isa low quarter forwarded");

    vga_off_a: assert property (i_txn_valid && !vga_enable
        |=> !o_vga_hit)
        else $error("display range forwarded while disabled");

    vga_mem_a: assert property (i_txn_valid && !i_txn_is_io && vga_enable
        && i_txn_addr == 64'h0000_0000_000b_ffff |=> o_vga_hit)
        else $error("display memory top not decoded");

    vga_io10_a: assert property (i_txn_valid && i_txn_is_io && vga_enable
        && i_txn_addr == 64'h0000_0000_0000_03bb |=> o_vga_hit)
        else $error("display io port not decoded");

    vga_io16_a: assert property (i_txn_valid && i_txn_is_io && vga_decode16
        && i_txn_addr[15:10] != 6'h00 |=> !o_vga_hit)
        else $error("16-bit decode matched alias");

    // reset outputs
    port_rst_a: assert property (sec_bus_reset && !i_port_is_upstream
        |=> o_port_reset)
        else $error("downstream hot reset not driven");

    all_rst_a: assert property (sec_bus_reset && i_port_is_upstream
        |=> &o_downstream_reset)
        else $error("upstream reset not spread");

    // main scenarios
    write_cov: cover property (wr_fire && i_avs_address[7:2] == OFF_INT_CTRL[7:2]);
    pref_cov: cover property (o_pref_hit);
    vga_cov: cover property (o_vga_hit && $past(i_txn_is_io));
    isa_cov: cover property (i_txn_valid && i_txn_is_io && isa_masked);
    rst_cov: cover property (o_port_reset ##1 !o_port_reset);
endmodule

// ==== verif/bwc_host.sv ====
// bwc_host: avalon-mm master standing in for the configuration host
`timescale 1ns/1ps
module bwc_host (
    // clock
    input wire logic i_clock,
    // avalon-mm master side
    output logic [7:0] o_address,
    output logic o_read,
    output logic o_write,
    output logic [3:0] o_byteenable,
    output logic [31:0] o_writedata,
    input wire logic [31:0] i_readdata,
    input wire logic i_waitrequest
);
    initial begin
        o_address = 8'h00;
        o_read = 1'b0;
        o_write = 1'b0;
        o_byteenable = 4'h0;
        o_writedata = 32'h0;
    end
    // one access; the request stands until waitrequest is sampled low or 16 cycles pass
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                          output logic [31:0] rdata, output logic ok);
        int n;
        ok = 1'b0;
        rdata = 32'h0;
        @(posedge i_clock);
        o_address <= a;
        o_writedata <= d;
        o_byteenable <= be;
        o_read <= ~wr;
        o_write <= wr;
        for (n = 0; n < 16 && !ok; n++) begin
            @(posedge i_clock);
            if (i_waitrequest === 1'b0) begin
                ok = 1'b1;
                rdata = i_readdata;
            end
        end
        o_read <= 1'b0;
        o_write <= 1'b0;
        // stale data must not look valid after release
        o_writedata <= ~d;
        o_address <= ~a;
    endtask
endmodule

// ==== verif/tb_bwc_regs.sv ====
// tb_bwc_regs: self-checking bench for the bridge window and control registers
`timescale 1ns/1ps
module tb_bwc_regs;
    import bwc_pkg::*;
    localparam logic [7:0] ADDRS [8] = '{OFF_PREF_BASE_UPPER, OFF_PREF_LIMIT_UPPER, OFF_IO_UPPER, OFF_CAP_PTR,
                                         OFF_INT_CTRL, OFF_PM_CAP, 8'h50, 8'h00};
    localparam logic [63:0] CORNERS [10] = '{64'h9_ffff, 64'ha_0000, 64'hb_ffff, 64'hc_0000, 64'h1000_0000,
                                             64'h1_0fff_ffff, 64'h1_1000_0000, 64'h3bb, 64'h3bc, 64'h7df};
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] adr;
    logic rd, wr;
    logic [3:0] be;
    logic [31:0] wdata, rdata;
    logic wait_req, up, pin_load, txn_valid, txn_io, txn_poison, err_valid, hot_reset;
    logic [7:0] pin_value;
    logic [11:0] pref_base_low, pref_limit_low;
    logic [3:0] io_base_low, io_limit_low;
    logic [63:0] txn_addr;
    logic pref_hit, io_hit, vga_hit, poison_report, err_forward, port_reset;
    logic [1:0] down_reset;
    logic [31:0] mdl [0:63];
    int miscompares = 0;
    int checks = 0;
    always #5 i_clock = ~i_clock;
    bwc_host host (.i_clock(i_clock), .o_address(adr), .o_read(rd), .o_write(wr), .o_byteenable(be),
                   .o_writedata(wdata), .i_readdata(rdata), .i_waitrequest(wait_req));
    bwc_regs #(.N_DOWN(2)) dut (.i_clock(i_clock), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_byteenable(be), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wait_req), .i_port_is_upstream(up), .i_pref_base_low(pref_base_low),
        .i_pref_limit_low(pref_limit_low), .i_io_base_low(io_base_low), .i_io_limit_low(io_limit_low),
        .i_int_pin_load(pin_load), .i_int_pin_value(pin_value), .i_txn_valid(txn_valid), .i_txn_is_io(txn_io),
        .i_txn_poisoned(txn_poison), .i_txn_addr(txn_addr), .i_err_msg_valid(err_valid),
        .i_upstream_hot_reset(hot_reset), .o_pref_hit(pref_hit), .o_io_hit(io_hit), .o_vga_hit(vga_hit),
        .o_poison_report(poison_report), .o_err_forward(err_forward), .o_port_reset(port_reset),
        .o_downstream_reset(down_reset));
    // ----------------------------------------------------------------
    // checking and expectation helpers
    // ----------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [31:0] wmask(input logic [7:0] a);
        case (a[7:2])
            OFF_PREF_BASE_UPPER[7:2], OFF_PREF_LIMIT_UPPER[7:2], OFF_IO_UPPER[7:2]: return 32'hffff_ffff;
            OFF_INT_CTRL[7:2]: return 32'h005f_00ff;
            default: return 32'h0000_0000;
        endcase
    endfunction
    function automatic logic [4:0] classify(input logic v, io, pz, em, input logic [63:0] a);
        logic [31:0] c;
        logic [63:0] plo, phi, ilo, ihi;
        logic vio;
        c = mdl[OFF_INT_CTRL[7:2]];
        plo = {mdl[OFF_PREF_BASE_UPPER[7:2]], pref_base_low, 20'h00000};
        phi = {mdl[OFF_PREF_LIMIT_UPPER[7:2]], pref_limit_low, 20'hfffff};
        ilo = {32'h0, mdl[OFF_IO_UPPER[7:2]][15:0], io_base_low, 12'h000};
        ihi = {32'h0, mdl[OFF_IO_UPPER[7:2]][31:16], io_limit_low, 12'hfff};
        vio = a[63:16] == 48'h0 && (!c[BIT_VGA16] || a[15:10] == 6'h00) &&
              ((a[9:0] >= 10'h3b0 && a[9:0] <= 10'h3bb) || (a[9:0] >= 10'h3c0 && a[9:0] <= 10'h3df));
        classify[4] = v && !io && a >= plo && a <= phi;
        classify[3] = v && io && a[63:32] == 32'h0 && a >= ilo && a <= ihi &&
                      !(c[BIT_ISA_EN] && a[63:16] == 48'h0 && a[9:8] == 2'b00);
        classify[2] = v && c[BIT_VGA_EN] && (io ? vio : (a >= 64'ha_0000 && a <= 64'hb_ffff));
        classify[1] = v && pz && c[BIT_PARITY_RESP];
        classify[0] = em && c[BIT_SERR_FWD];
    endfunction
    task automatic reset_model();
        foreach (mdl[i]) mdl[i] = 32'h0;
        mdl[OFF_CAP_PTR[7:2]] = 32'h0000_0040;
        mdl[OFF_PM_CAP[7:2]] = 32'h0000_0001;
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        logic [31:0] r, m;
        logic ok;
        host.access(1'b1, a, d, b, r, ok);
        check("write answered", ok, 1'b1);
        if (!ok) print_verdict();
        m = wmask(a) & {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
        mdl[a[7:2]] = (mdl[a[7:2]] & ~m) | (d & m);
    endtask
    task automatic bus_rd(input logic [7:0] a);
        logic [31:0] r;
        logic ok;
        host.access(1'b0, a, 32'h0, 4'hf, r, ok);
        check("read answered", ok, 1'b1);
        if (!ok) print_verdict();
        check($sformatf("register %h", a), r, mdl[a[7:2]]);
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [4:0] exp, nxt;
        logic [63:0] a;
        {up, pin_load, pin_value, txn_valid, txn_io, txn_poison, err_valid, hot_reset, txn_addr} = '0;
        {pref_base_low, pref_limit_low, io_base_low, io_limit_low} = {12'h100, 12'h0ff, 4'h2, 4'hd};
        exp = 5'h00;
        reset_model();
        void'($urandom(32'ha403b98e));
        repeat (3) @(posedge i_clock);
        i_rst <= 1'b0;
        foreach (ADDRS[i]) bus_rd(ADDRS[i]);
        $display("test reset_values done");
        repeat (24) begin
            a[7:0] = ADDRS[$urandom % 8];
            bus_wr(a[7:0], $urandom, 4'($urandom));
            bus_rd(a[7:0]);
        end
        $display("test random_access done");
        for (int k = 1; k >= 0; k--) begin
            @(posedge i_clock);
            up <= k[0];
            pin_load <= 1'b1;
            pin_value <= 8'($urandom) | 8'h01;
            @(posedge i_clock);
            pin_load <= 1'b0;
            if (k == 0) mdl[OFF_INT_CTRL[7:2]][15:8] = pin_value;
            bus_rd(OFF_INT_CTRL);
        end
        $display("test pin_default done");
        bus_wr(OFF_PREF_BASE_UPPER, 32'h0, 4'hf);
        bus_wr(OFF_PREF_LIMIT_UPPER, 32'h1, 4'hf);
        bus_wr(OFF_IO_UPPER, 32'h0001_0000, 4'hf);
        for (int k = 0; k < 32; k++) begin
            bus_wr(OFF_INT_CTRL, {11'h0, k[4:0], 16'h0000}, 4'hc);
            for (int n = 0; n <= 12; n++) begin
                @(posedge i_clock);
                case ($urandom % 4)
                    0: a = {32'($urandom % 3), 32'($urandom)};
                    1: a = {48'h0, 16'($urandom)};
                    2: a = CORNERS[$urandom % 10];
                    default: a = {32'h0, 16'($urandom % 3), 16'($urandom)};
                endcase
                nxt = 5'($urandom);
                txn_valid <= nxt[4] && n < 12;
                txn_io <= nxt[3];
                txn_poison <= nxt[2];
                err_valid <= nxt[1] && n < 12;
                txn_addr <= a;
                nxt = classify(nxt[4] && n < 12, nxt[3], nxt[2], nxt[1] && n < 12, a);
                #1;
                if (n > 0) check("classify", {pref_hit, io_hit, vga_hit, poison_report, err_forward}, exp);
                exp = nxt;
            end
        end
        $display("test classify done");
        for (int k = 0; k < 8; k++) begin
            @(posedge i_clock);
            up <= k[0];
            hot_reset <= k[1];
            bus_wr(OFF_INT_CTRL, {9'h0, k[2], 22'h0}, 4'hc);
            repeat (2) @(posedge i_clock);
            #1;
            check("port reset", port_reset, (k[2] & !k[0]) | k[1]);
            check("downstream reset", down_reset, {2{k[2] & k[0]}});
        end
        $display("test hot_reset done");
        @(posedge i_clock);
        i_rst <= 1'b1;
        @(posedge i_clock);
        i_rst <= 1'b0;
        reset_model();
        bus_rd(OFF_PREF_LIMIT_UPPER);
        bus_rd(OFF_INT_CTRL);
        $display("test second_reset done");
        print_verdict();
    end
endmodule
